// ==== logic/pcrm_pkg.sv ====
// package of constants and types for the paged control register map
package pcrm_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int PCRM_LOC_W = 7;
  localparam int PCRM_DATA_W = 8;
  localparam int PCRM_PAGE_W = 8;

  // ---------------------------------------------------------------
  // locations common to page 0
  // ---------------------------------------------------------------
  localparam logic [6:0] LOC_PAGE_SELECT = 7'h00;
  localparam logic [6:0] LOC_SOFTWARE_RESET = 7'h01;
  localparam logic [6:0] LOC_REVISION_INFO = 7'h02;
  localparam logic [6:0] LOC_RESERVED_SLOT_THREE = 7'h03;

  // ---------------------------------------------------------------
  // page numbers
  // ---------------------------------------------------------------
  localparam logic [7:0] PAGE_CONTROL = 8'h00;
  localparam logic [7:0] PAGE_ROUTING = 8'h01;
  localparam logic [7:0] PAGE_COEF_LOW = 8'h04;
  localparam logic [7:0] PAGE_COEF_HIGH = 8'h05;
  localparam logic [7:0] PAGE_INSTR_FIRST = 8'h20;
  localparam logic [7:0] PAGE_INSTR_LAST = 8'h2F;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
  localparam logic [7:0] SOFTWARE_RESET_RST = 8'h00;
  localparam int SW_RESET_BIT = 0;
  localparam int REV_LSB = 4;
  localparam int REV_W = 3;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // memory windows
  // ---------------------------------------------------------------
  localparam logic [6:0] COEF_LOC_FIRST = 7'h01;
  localparam logic [6:0] COEF_LOC_LAST = 7'h3F;
  localparam logic [6:0] INSTR_LOC_FIRST = 7'h01;
  localparam logic [6:0] INSTR_LOC_LAST = 7'h20;
  localparam int COEF_DEPTH = 128;
  localparam int COEF_AW = 7;
  localparam int INSTR_DEPTH = 512;
  localparam int INSTR_AW = 9;

  // host register request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] loc;
    logic [7:0] wdata;
  } pcrm_req_t;

  // decoded target of an access
  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_PAGE = 3'b001,
    TGT_SWRST = 3'b011,
    TGT_REV = 3'b010,
    TGT_COEF = 3'b110,
    TGT_INSTR = 3'b111
  } pcrm_tgt_t;

  typedef struct packed {
    pcrm_tgt_t tgt;
    logic [8:0] idx;
  } pcrm_dec_t;

endpackage

// ==== logic/pcrm_ram.sv ====
// dual read port memory for filter coefficients and instructions
`timescale 1ns/1ps
module pcrm_ram #(
  parameter int W = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_a_addr,
  output logic [W-1:0] rd_a_data,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [W-1:0] rd_b_data
);

  logic [W-1:0] mem [DEPTH];

  // ---------------------------------------------------------------
  // write port and registered read ports
  // ---------------------------------------------------------------
  // contents are not reset, like any ram
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_a_data <= mem[rd_a_addr];
    rd_b_data <= mem[rd_b_addr];
  end

endmodule

// ==== logic/pcrm_regmap.sv ====
// paged control register map with coefficient and instruction ram windows
`timescale 1ns/1ps

// Function
// [R1] the page selector is an 8-bit read/write register reset to zero and the selected page is exposed.
// [R2] writing one to bit 0 of the software reset register restores control defaults and the bit clears itself.
// [R3] the host keeps the upper seven bits of the software reset register at zero.
// [R4] the 3-bit revision field reads a fixed value and host writes to it are ignored.
// [R5] the host writes only reset values to the reserved bits of the revision register.
// [R6] the host makes no access while page two or three is selected.
// [R7] page 4 maps coefficient entries 1 to 63 and page 5 maps entries 65 to 127.
// [R8] pages 32 to 47 map the 512-entry instruction ram, 32 instructions per page.
// [R9] the host makes no access while pages 6 to 31 or 48 to 255 are selected.
// [R10] the host never writes location 3 of page 0.
// [R11] location 0 of every page addresses the same page selector.
// [R12] reserved locations read as zero and writes to them change nothing.
module pcrm_regmap #(
  parameter logic [2:0] REVISION_CODE = 3'h5, // arbitrary value
  parameter int COEF_W = 8,
  parameter int INSTR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input pcrm_pkg::pcrm_req_t host_req,
  output logic [pcrm_pkg::PCRM_DATA_W-1:0] host_rdata,
  output logic host_rvalid,
  output logic [pcrm_pkg::PCRM_PAGE_W-1:0] page_select,
  output logic ctrl_reset_pulse,
  input wire logic [pcrm_pkg::COEF_AW-1:0] coef_rd_addr,
  output logic [COEF_W-1:0] coef_rd_data,
  input wire logic [pcrm_pkg::INSTR_AW-1:0] instr_rd_addr,
  output logic [INSTR_W-1:0] instr_rd_data
);
  import pcrm_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------

  // map a page and location onto a target and memory index
  function automatic pcrm_dec_t decode(input logic [7:0] page, input logic [6:0] loc);
    pcrm_dec_t d;
    logic [6:0] off;
    d.tgt = TGT_NONE;
    d.idx = '0;
    off = loc - INSTR_LOC_FIRST;
    if (loc == LOC_PAGE_SELECT) begin
      d.tgt = TGT_PAGE; // [R11]
    end else if (page == PAGE_CONTROL && loc == LOC_SOFTWARE_RESET) begin
      d.tgt = TGT_SWRST;
    end else if (page == PAGE_CONTROL && loc == LOC_REVISION_INFO) begin
      d.tgt = TGT_REV;
    end else if ((page == PAGE_COEF_LOW || page == PAGE_COEF_HIGH) &&
                 loc >= COEF_LOC_FIRST && loc <= COEF_LOC_LAST) begin
      // page 4 gives entries 1..63, page 5 gives 65..127
      d.tgt = TGT_COEF; // [R7]
      d.idx = {2'b00, (page == PAGE_COEF_HIGH), loc[5:0]};
    end else if (page >= PAGE_INSTR_FIRST && page <= PAGE_INSTR_LAST &&
                 loc >= INSTR_LOC_FIRST && loc <= INSTR_LOC_LAST) begin
      // instruction 32k + (loc - 1) on page 32 + k
      d.tgt = TGT_INSTR; // [R8]
      d.idx = {page[3:0], off[4:0]};
    end
    // everything else, reserved slot three included, stays TGT_NONE
    return d;
  endfunction

  logic [7:0] page_select_reg;
  logic [7:0] page_select_next;
  logic sw_reset_reg;
  logic sw_reset_next;
  pcrm_dec_t host_dec;
  logic coef_wr_en;
  logic instr_wr_en;
  logic [COEF_W-1:0] coef_host_data;
  logic [INSTR_W-1:0] instr_host_data;
  logic [COEF_W-1:0] coef_wr_data;
  logic [INSTR_W-1:0] instr_wr_data;

  // current access against current page
  always_comb begin
    host_dec = decode(page_select_reg, host_req.loc);
  end

  // ram write strobes, reserved targets get none
  assign coef_wr_en = host_req.wr && host_dec.tgt == TGT_COEF; // [R7] [R12]
  assign instr_wr_en = host_req.wr && host_dec.tgt == TGT_INSTR; // [R8] [R12]
  assign coef_wr_data = COEF_W'(host_req.wdata);
  assign instr_wr_data = INSTR_W'(host_req.wdata);

  // ---------------------------------------------------------------
  // memories
  // ---------------------------------------------------------------

  // coefficient ram, host port and filter engine port
  pcrm_ram #(
    .W(COEF_W),
    .DEPTH(COEF_DEPTH),
    .AW(COEF_AW)
  ) u_coef_ram (
    .sys_clk(sys_clk),
    .wr_en(coef_wr_en),
    .wr_addr(host_dec.idx[COEF_AW-1:0]),
    .wr_data(coef_wr_data),
    .rd_a_addr(host_dec.idx[COEF_AW-1:0]),
    .rd_a_data(coef_host_data),
    .rd_b_addr(coef_rd_addr),
    .rd_b_data(coef_rd_data)
  );

  // instruction ram, host port and filter engine port
  pcrm_ram #(
    .W(INSTR_W),
    .DEPTH(INSTR_DEPTH),
    .AW(INSTR_AW)
  ) u_instr_ram (
    .sys_clk(sys_clk),
    .wr_en(instr_wr_en),
    .wr_addr(host_dec.idx[INSTR_AW-1:0]),
    .wr_data(instr_wr_data),
    .rd_a_addr(host_dec.idx[INSTR_AW-1:0]),
    .rd_a_data(instr_host_data),
    .rd_b_addr(instr_rd_addr),
    .rd_b_data(instr_rd_data)
  );

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------

  // page selector and self-clearing software reset
  always_comb begin
    page_select_next = page_select_reg;
    sw_reset_next = 1'b0; // self clears one cycle after it is set
    if (host_req.wr && host_dec.tgt == TGT_PAGE) begin
      page_select_next = host_req.wdata; // [R1] [R11]
    end
    if (host_req.wr && host_dec.tgt == TGT_SWRST && host_req.wdata[SW_RESET_BIT]) begin
      // writing zero falls through and does nothing
      sw_reset_next = 1'b1; // [R2]
      page_select_next = PAGE_SELECT_RST; // [R2]
    end
  end

  // register the control state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      page_select_reg <= PAGE_SELECT_RST; // [R1]
      sw_reset_reg <= SOFTWARE_RESET_RST[SW_RESET_BIT];
    end else begin
      page_select_reg <= page_select_next;
      sw_reset_reg <= sw_reset_next;
    end
  end

  assign page_select = page_select_reg;
  assign ctrl_reset_pulse = sw_reset_reg;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  logic rd_pend_reg;
  logic rd_pend_next;
  pcrm_tgt_t rd_tgt_reg;
  pcrm_tgt_t rd_tgt_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // remember the target while the ram reads, then select the answer
  always_comb begin
    rd_pend_next = host_req.rd;
    rd_tgt_next = host_req.rd ? host_dec.tgt : TGT_NONE;
    rvalid_next = rd_pend_reg;
    rdata_next = READ_ZERO; // [R12]
    if (rd_pend_reg) begin
      unique case (rd_tgt_reg)
        TGT_PAGE: begin
          rdata_next = page_select_reg; // [R1]
        end
        TGT_SWRST: begin
          rdata_next = {7'h00, sw_reset_reg}; // [R2]
        end
        TGT_REV: begin
          // fixed field, reserved bits read as zero
          rdata_next = READ_ZERO;
          rdata_next[REV_LSB +: REV_W] = REVISION_CODE; // [R4]
        end
        TGT_COEF: begin
          rdata_next = 8'(coef_host_data); // [R7]
        end
        TGT_INSTR: begin
          rdata_next = 8'(instr_host_data); // [R8]
        end
        TGT_NONE: begin
          rdata_next = READ_ZERO; // [R12]
        end
      endcase
    end
  end

  // register the read pipeline
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_pend_reg <= 1'b0;
      rd_tgt_reg <= TGT_NONE;
      rdata_reg <= READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rd_pend_reg <= rd_pend_next;
      rd_tgt_reg <= rd_tgt_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign host_rdata = rdata_reg;
  assign host_rvalid = rvalid_reg;

endmodule

// ==== dv/pcrm_regmap_asserts.sv ====
// assertion checker for the paged control register map
`timescale 1ns/1ps
module pcrm_regmap_asserts #(
  parameter logic [2:0] REVISION_CODE = 3'h5
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input pcrm_pkg::pcrm_req_t host_req,
  input wire logic [pcrm_pkg::PCRM_DATA_W-1:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic [pcrm_pkg::PCRM_PAGE_W-1:0] page_select,
  input wire logic ctrl_reset_pulse
);
  import pcrm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // decode helpers
  wire p0 = page_select == PAGE_CONTROL;
  wire [6:0] loc = host_req.loc;
  wire pg_wr = host_req.wr && loc == LOC_PAGE_SELECT;
  wire swr = host_req.wr && p0 && loc == LOC_SOFTWARE_RESET && host_req.wdata[SW_RESET_BIT];
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  rvalid_lat_a: assert property (host_req.rd |-> ##2 host_rvalid)
    else $error("read answer missing");
  page_wr_a: assert property (pg_wr |=> page_select == $past(host_req.wdata))
    else $error("page write lost");
  page_keep_a: assert property (!pg_wr && !swr |=> $stable(page_select))
    else $error("page changed unasked");
  swrst_pulse_a: assert property (swr |=> ctrl_reset_pulse && page_select == PAGE_SELECT_RST)
    else $error("soft reset missing");
  swrst_cause_a: assert property (ctrl_reset_pulse |-> $past(swr))
    else $error("soft reset unasked");
  rev_read_a: assert property (host_req.rd && p0 && loc == LOC_REVISION_INFO |->
    ##2 host_rdata == {1'b0, REVISION_CODE, 4'h0}) else $error("bad revision read");
  slot_read_a: assert property (host_req.rd && p0 && loc == LOC_RESERVED_SLOT_THREE |->
    ##2 host_rdata == READ_ZERO) else $error("reserved slot not zero");
  // the answer shows the page as it stands one edge after the request
  page_read_a: assert property (host_req.rd && loc == LOC_PAGE_SELECT |->
    ##2 host_rdata == $past(page_select)) else $error("bad page read");
endmodule
bind pcrm_regmap pcrm_regmap_asserts #(.REVISION_CODE(REVISION_CODE)) i_asserts (.sys_clk(sys_clk),
  .rst_n(rst_n), .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
  .page_select(page_select), .ctrl_reset_pulse(ctrl_reset_pulse));

// ==== dv/pcrm_host_model.sv ====
// host controller model issuing register requests
`timescale 1ns/1ps
module pcrm_host_model (
  input wire logic sys_clk,
  output pcrm_pkg::pcrm_req_t host_req,
  input wire logic [pcrm_pkg::PCRM_DATA_W-1:0] host_rdata,
  input wire logic host_rvalid
);
  import pcrm_pkg::*;
  logic [7:0] cur_page = 8'h00;
  initial host_req = '0;
  // valid pages only
  function automatic logic ok(logic [7:0] p);
    return p inside {8'h00, 8'h01, 8'h04, 8'h05, [8'h20:8'h2F]};
  endfunction
  // one write, reserved bits kept at reset value
  task automatic wr(input logic [6:0] l, input logic [7:0] d);
    if (!ok(cur_page) || (l == 7'h00 && !ok(d))) return;
    if (cur_page == 8'h00 && l == LOC_RESERVED_SLOT_THREE) return;
    if (cur_page == 8'h00 && l == LOC_SOFTWARE_RESET) d = d & 8'h01;
    if (cur_page == 8'h00 && l == LOC_REVISION_INFO) d = d & 8'h70;
    @(negedge sys_clk);
    host_req <= '{1'b1, 1'b0, l, d};
    @(negedge sys_clk);
    host_req <= '{1'b0, 1'b0, ~l, ~d}; // idle lines show no stale value
    if (l == 7'h00) cur_page = d;
  endtask
  // one read, answer awaited a bounded time
  task automatic rd(input logic [6:0] l, output logic [7:0] q);
    q = 8'hXX;
    if (!ok(cur_page)) return;
    @(negedge sys_clk);
    host_req <= '{1'b0, 1'b1, l, 8'h5A};
    @(negedge sys_clk);
    host_req <= '{1'b0, 1'b0, ~l, 8'hA5};
    repeat (3) begin
      @(posedge sys_clk);
      #1;
      if (host_rvalid === 1'b1) begin
        q = host_rdata;
        return;
      end
    end
  endtask
endmodule

// ==== dv/test_paged_control_register_map.sv ====
// self-checking testbench of the paged control register map
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module test_paged_control_register_map;
  import pcrm_pkg::*;
  localparam logic [2:0] REV = 3'h3; // arbitrary value
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  pcrm_req_t host_req;
  logic [7:0] host_rdata, page_select, coef_rd_data, instr_rd_data, q;
  logic host_rvalid, ctrl_reset_pulse;
  logic [6:0] coef_rd_addr = 7'h00;
  logic [8:0] instr_rd_addr = 9'h000;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #20 sys_clk = ~sys_clk;
  pcrm_regmap #(.REVISION_CODE(REV)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .page_select(page_select),
    .ctrl_reset_pulse(ctrl_reset_pulse), .coef_rd_addr(coef_rd_addr), .coef_rd_data(coef_rd_data),
    .instr_rd_addr(instr_rd_addr), .instr_rd_data(instr_rd_data));
  pcrm_host_model i_host (.sys_clk(sys_clk), .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid));
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // page select from several pages
  task automatic t_page();
    logic [7:0] pages [3] = '{8'h04, 8'h2F, 8'h00};
    `CHK({page_select, host_rdata, host_rvalid}, 17'h00000)
    foreach (pages[i]) begin
      i_host.wr(LOC_PAGE_SELECT, pages[i]);
      `CHK(page_select, pages[i])
      i_host.rd(LOC_PAGE_SELECT, q);
      `CHK(q, pages[i])
    end
  endtask
  // revision field and reserved places
  task automatic t_rev();
    i_host.wr(LOC_REVISION_INFO, 8'h70);
    i_host.rd(LOC_REVISION_INFO, q);
    `CHK(q, {1'b0, REV, 4'h0})
    i_host.wr(7'h09, 8'hFF);
    `CHK(page_select, 8'h00)
    i_host.rd(7'h09, q);
    `CHK(q, 8'h00)
    i_host.rd(LOC_RESERVED_SLOT_THREE, q);
    `CHK(q, 8'h00)
  endtask
  // soft reset ignores zero, pulses on one
  task automatic t_swrst();
    i_host.wr(LOC_SOFTWARE_RESET, 8'h00);
    `CHK(ctrl_reset_pulse, 1'b0)
    `CHK(page_select, 8'h00)
    i_host.wr(LOC_SOFTWARE_RESET, 8'hFF);
    `CHK(ctrl_reset_pulse, 1'b1)
    @(negedge sys_clk);
    `CHK(ctrl_reset_pulse, 1'b0)
    i_host.rd(LOC_SOFTWARE_RESET, q);
    `CHK(q, 8'h00)
  endtask
  // memory windows from host and engine side
  task automatic t_mem();
    logic [7:0] pg [8] = '{8'h04, 8'h04, 8'h05, 8'h05, 8'h20, 8'h20, 8'h2F, 8'h2F};
    logic [6:0] lc [8] = '{7'h01, 7'h3F, 7'h01, 7'h3F, 7'h01, 7'h20, 7'h01, 7'h20};
    logic [8:0] ad [8] = '{9'd1, 9'd63, 9'd65, 9'd127, 9'd0, 9'd31, 9'd480, 9'd511};
    foreach (pg[i]) begin
      i_host.wr(LOC_PAGE_SELECT, pg[i]);
      i_host.wr(lc[i], 8'h80 + 8'(i));
      i_host.rd(lc[i], q);
      `CHK(q, 8'h80 + 8'(i))
      @(negedge sys_clk);
      coef_rd_addr = ad[i][6:0];
      instr_rd_addr = ad[i];
      @(posedge sys_clk);
      #1;
      `CHK(pg[i] < 8'h20 ? coef_rd_data : instr_rd_data, 8'h80 + 8'(i))
    end
    i_host.rd(7'h40, q);
    `CHK(q, 8'h00)
    i_host.wr(LOC_PAGE_SELECT, 8'h00);
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    t_page();
    t_rev();
    t_swrst();
    t_mem();
    complete_run();
  end
endmodule
